/* File: include/bsit_defines.svh */
// constants for the bus statistics and instruction trace block
//
// Overview of operation
// - stats_filter_bit set: trace filters suppress statistics events of masked transfers, all except split delay.
// - idle, busy, nonseq, seq events follow HTRANS while HREADY is high.
// - read and write events for SEQ or NONSEQ with HREADY, split by HWRITE.
// - six-bit size event vector, bit of HSIZE set on SEQ/NONSEQ with HREADY.
// - wait_state_event whenever HREADY is low and response is OKAY.
// - retry and split events when a master gets RETRY or SPLIT.
// - store split master index, split delay high until that master is granted again.
// - only one split master tracked; later splits during the delay are ignored.
// - locked event high while HMASTLOCK is high.
// - executed instructions go to a circular buffer of 128-bit lines, wrapping.
// - line holds time tag 125:96, result 95:64, pc 63:34, opcode 31:0.
// - bit 33 marks a trap, bit 32 marks processor error mode.
// - one line per instruction; second line of multi-cycle ones sets bit 126.
// - stores record store address, loads record loaded data in the result field.
// - tracing suspended in debug mode, resumed in normal mode.
// - buffer and control 0 writable only in debug mode, writes ignored otherwise.
// - filter field 31:28: 0 all, 1 format 2, 2 control flow, 4 calls.
// - codes 8, C, D, E select format 3 classes and alternate space accesses.
// - alternate space 80 to FF loads and stores start no bus transfer.
// - after reset tracing enabled when debug_enable_in high and break input low.
// - time tag counter frozen while the processor is in debug mode.
// - filters mask by master, slave, read, write and address range.
`ifndef BSIT_DEFINES_SVH
`define BSIT_DEFINES_SVH
// register offsets
`define BSIT_A_CTRL0 16'h0000
`define BSIT_A_TTAG 16'h0004
`define BSIT_A_FCTL 16'h0008
`define BSIT_A_FMSK 16'h000c
`define BSIT_A_ABASE 16'h0010
`define BSIT_A_AMASK 16'h0014
`define BSIT_A_STAT 16'h0018
`define BSIT_BUF_SEL 6'h04
// field positions
`define BSIT_F_SF 0
`define BSIT_F_MRD 1
`define BSIT_F_MWR 2
`define BSIT_F_AEN 3
`define BSIT_F_EN 16
`define BSIT_F_FHI 31
`define BSIT_F_FLO 28
// reset values
`define BSIT_RST_FILT 4'h0
`define BSIT_RST_FCTL 4'h0
`define BSIT_RST_WORD 32'h0000_0000
// sizes
`define BSIT_LINES 64
`endif

/* File: include/bsit_pkg.sv */
// types for the bus statistics and instruction trace block
package bsit_pkg;
  typedef enum logic [1:0] {HT_IDLE = 2'h0, HT_BUSY = 2'h1, HT_NSEQ = 2'h2, HT_SEQ = 2'h3} bsit_htrans_t;
  typedef enum logic [1:0] {HR_OKAY = 2'h0, HR_ERR = 2'h1, HR_RETRY = 2'h2, HR_SPLIT = 2'h3} bsit_hresp_t;
  typedef enum logic [1:0] {SP_IDLE = 2'b01, SP_WAIT = 2'b10} bsit_sp_t;
  typedef enum logic [3:0] {
    FL_ALL = 4'h0, FL_FMT2 = 4'h1, FL_CFLOW = 4'h2, FL_CALL = 4'h4,
    FL_F3OP = 4'h8, FL_F3LS = 4'hc, FL_ALT = 4'hd, FL_ALTHI = 4'he
  } bsit_filt_t;
endpackage : bsit_pkg

/* File: rtl/bsit_top.sv */
// bus statistics events and instruction trace buffer
//
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`include "bsit_defines.svh"
module bsit_top import bsit_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // register port
  input wire logic [15:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // traced bus, slave side
  input wire logic [1:0] htrans,
  input wire logic hready,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [1:0] hresp,
  input wire logic [3:0] hmaster,
  input wire logic hmastlock,
  input wire logic [31:0] haddr,
  input wire logic [3:0] hslave,
  // events to the statistics counter unit
  output logic evt_idle,
  output logic evt_busy,
  output logic evt_nseq,
  output logic evt_seq,
  output logic evt_read,
  output logic evt_write,
  output logic [5:0] evt_hsize,
  output logic wait_state_event,
  output logic evt_retry,
  output logic evt_split,
  output logic evt_split_delay,
  output logic evt_locked,
  // processor state
  input wire logic debug_mode,
  input wire logic debug_enable_in,
  input wire logic ext_break_in,
  // retired instruction
  input wire logic instr_valid,
  input wire logic [31:0] instr_opcode,
  input wire logic [31:0] instr_pc,
  input wire logic [31:0] instr_result,
  input wire logic instr_store,
  input wire logic [31:0] instr_store_addr,
  input wire logic instr_trap,
  input wire logic instr_error,
  input wire logic instr_second,
  input wire logic instr_target,
  // bus suppression for trace points
  output logic asi_bus_suppress
);

  // ----------------------------------------
  // opcode helpers
  // ----------------------------------------

  // load/store to alternate space 80..ff
  function automatic logic bsit_asi_hi(input logic [31:0] o);
    return (o[31:30] == 2'b11) & o[23] & ~o[13] & o[12];
  endfunction : bsit_asi_hi

  // instruction class against the filter code
  function automatic logic bsit_filt_pass(input logic [31:0] o, input logic tgt,
                                          input logic [3:0] c);
    logic [1:0] op;
    logic bra;
    logic f3cf;
    op = o[31:30];
    bra = (op == 2'b00) & (o[24:22] == 3'b010 | o[24:22] == 3'b110 | o[24:22] == 3'b111);
    f3cf = (op == 2'b10) & (o[24:19] == 6'h38 | o[24:19] == 6'h39 | o[24:19] == 6'h3a);
    case (c)
      FL_ALL: return 1'b1;
      FL_FMT2: return op == 2'b00;
      FL_CFLOW: return tgt | bra | f3cf | (op == 2'b01);
      FL_CALL: return op == 2'b01;
      FL_F3OP: return op == 2'b10;
      FL_F3LS: return op == 2'b11;
      FL_ALT: return (op == 2'b11) & o[23];
      FL_ALTHI: return bsit_asi_hi(o);
      default: return 1'b0;
    endcase
  endfunction : bsit_filt_pass

  // ----------------------------------------
  // registers and state
  // ----------------------------------------
  logic [3:0] fctl_q;
  logic [31:0] fmsk_q;
  logic [31:0] abase_q;
  logic [31:0] amask_q;
  logic [3:0] filt_q;
  logic en_q;
  logic boot_q;
  logic [5:0] wptr_q;
  logic [29:0] ttag_q;
  logic [31:0] rdata_q;
  logic [127:0] tbuf [`BSIT_LINES];
  bsit_sp_t sp_q;
  logic [3:0] spm_q;
  logic [3:0] dp_master_q;
  logic dp_pass_q;
  logic idle_q, busy_q, nseq_q, seq_q, rd_q, wr_q, ws_q, retry_q, split_q, lock_q;
  logic [5:0] hsize_q;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  logic dbg_wr;
  logic buf_sel;
  logic ctrl_wr;
  logic tt_wr;
  logic buf_wr;
  logic [5:0] li;
  logic [6:0] wsel;
  assign dbg_wr = reg_wr & debug_mode;
  assign buf_sel = reg_addr[15:10] == `BSIT_BUF_SEL;
  assign ctrl_wr = dbg_wr & (reg_addr == `BSIT_A_CTRL0);
  assign tt_wr = dbg_wr & (reg_addr == `BSIT_A_TTAG);
  assign buf_wr = dbg_wr & buf_sel;
  assign li = reg_addr[9:4];
  // word 0 of a line is its top 32 bits
  assign wsel = {~reg_addr[3:2], 5'h00};

  // ----------------------------------------
  // bus filters
  // ----------------------------------------
  logic addr_hit;
  logic masked;
  logic pass;
  logic xfer;
  logic split_first;
  logic regrant;
  // range match uses the mask so a zero mask matches everything
  assign addr_hit = fctl_q[`BSIT_F_AEN] & ((haddr & amask_q) == (abase_q & amask_q));
  assign masked = fmsk_q[{1'b0, hmaster}] | fmsk_q[{1'b1, hslave}] | addr_hit
                | (fctl_q[`BSIT_F_MRD] & ~hwrite) | (fctl_q[`BSIT_F_MWR] & hwrite);
  assign pass = ~fctl_q[`BSIT_F_SF] | ~masked;
  assign xfer = hready & (htrans == HT_SEQ | htrans == HT_NSEQ);
  // first cycle of the two-cycle split response
  assign split_first = (hresp == HR_SPLIT) & ~hready;
  assign regrant = (hmaster == spm_q) & hready & (htrans == HT_NSEQ);

  // data phase master and filter verdict follow the address phase
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      dp_master_q <= 4'h0;
      dp_pass_q <= 1'b1;
    end else if (hready) begin
      dp_master_q <= hmaster;
      dp_pass_q <= pass;
    end
  end

  // ----------------------------------------
  // statistics events
  // ----------------------------------------

  // every event registered, one cycle per qualifying cycle
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      idle_q <= 1'b0;
      busy_q <= 1'b0;
      nseq_q <= 1'b0;
      seq_q <= 1'b0;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      hsize_q <= 6'h00;
      ws_q <= 1'b0;
      retry_q <= 1'b0;
      split_q <= 1'b0;
      lock_q <= 1'b0;
    end else begin
      idle_q <= pass & hready & (htrans == HT_IDLE);
      busy_q <= pass & hready & (htrans == HT_BUSY);
      nseq_q <= pass & hready & (htrans == HT_NSEQ);
      seq_q <= pass & hready & (htrans == HT_SEQ);
      rd_q <= pass & xfer & ~hwrite;
      wr_q <= pass & xfer & hwrite;
      hsize_q <= (pass & xfer) ? (6'h01 << hsize) : 6'h00;
      ws_q <= dp_pass_q & ~hready & (hresp == HR_OKAY);
      retry_q <= dp_pass_q & (hresp == HR_RETRY) & ~hready;
      split_q <= dp_pass_q & split_first;
      lock_q <= pass & hmastlock;
    end
  end

  // split delay tracker, one master at a time
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sp_q <= SP_IDLE;
      spm_q <= 4'h0;
    end else begin
      case (sp_q)
        SP_IDLE: begin
          if (split_first) begin
            sp_q <= SP_WAIT;
            spm_q <= dp_master_q;
          end
        end
        // further splits are not captured here
        SP_WAIT: begin
          if (regrant) begin
            sp_q <= SP_IDLE;
          end
        end
        default: sp_q <= SP_IDLE;
      endcase
    end
  end

  assign evt_idle = idle_q;
  assign evt_busy = busy_q;
  assign evt_nseq = nseq_q;
  assign evt_seq = seq_q;
  assign evt_read = rd_q;
  assign evt_write = wr_q;
  assign evt_hsize = hsize_q;
  assign wait_state_event = ws_q;
  assign evt_retry = retry_q;
  assign evt_split = split_q;
  assign evt_split_delay = sp_q == SP_WAIT;
  assign evt_locked = lock_q;

  // ----------------------------------------
  // instruction trace
  // ----------------------------------------
  logic trace_go;
  logic [31:0] res;
  logic [127:0] line;
  assign trace_go = instr_valid & en_q & ~debug_mode & bsit_filt_pass(instr_opcode, instr_target, filt_q);
  assign res = instr_store ? instr_store_addr : instr_result;
  assign line = {1'b0, instr_second, ttag_q, res, instr_pc[31:2], instr_trap, instr_error, instr_opcode};
  assign asi_bus_suppress = instr_valid & bsit_asi_hi(instr_opcode);

  // control 0; enable taken one cycle after reset release
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      filt_q <= `BSIT_RST_FILT;
      en_q <= 1'b0;
      boot_q <= 1'b1;
      wptr_q <= 6'h00;
    end else begin
      boot_q <= 1'b0;
      if (boot_q) begin
        en_q <= debug_enable_in & ~ext_break_in;
      end else if (ctrl_wr) begin
        en_q <= reg_wdata[`BSIT_F_EN];
      end
      if (ctrl_wr) begin
        filt_q <= reg_wdata[`BSIT_F_FHI:`BSIT_F_FLO];
        wptr_q <= reg_wdata[5:0];
      end else if (trace_go) begin
        wptr_q <= wptr_q + 6'h01;
      end
    end
  end

  // time tag, halted in debug so traces stay comparable
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ttag_q <= 30'h0000_0000;
    end else if (tt_wr) begin
      ttag_q <= reg_wdata[29:0];
    end else if (!debug_mode) begin
      ttag_q <= ttag_q + 30'h0000_0001;
    end
  end

  // buffer memory; trace and bus writes never coincide
  always_ff @(posedge clk) begin
    if (trace_go) begin
      tbuf[wptr_q] <= line;
    end else if (buf_wr) begin
      tbuf[li][wsel +: 32] <= reg_wdata;
    end
  end

  // ----------------------------------------
  // filter registers, writable at any time
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      fctl_q <= `BSIT_RST_FCTL;
      fmsk_q <= `BSIT_RST_WORD;
      abase_q <= `BSIT_RST_WORD;
      amask_q <= `BSIT_RST_WORD;
    end else if (reg_wr) begin
      if (reg_addr == `BSIT_A_FCTL) fctl_q <= reg_wdata[3:0];
      if (reg_addr == `BSIT_A_FMSK) fmsk_q <= reg_wdata;
      if (reg_addr == `BSIT_A_ABASE) abase_q <= reg_wdata;
      if (reg_addr == `BSIT_A_AMASK) amask_q <= reg_wdata;
    end
  end

  // ----------------------------------------
  // read back, one cycle after the strobe
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdata_q <= `BSIT_RST_WORD;
    end else if (reg_rd) begin
      if (buf_sel) begin
        rdata_q <= tbuf[li][wsel +: 32];
      end else begin
        case (reg_addr)
          `BSIT_A_CTRL0: rdata_q <= {filt_q, 11'h000, en_q, 10'h000, wptr_q};
          `BSIT_A_TTAG: rdata_q <= {2'b00, ttag_q};
          `BSIT_A_FCTL: rdata_q <= {28'h0000000, fctl_q};
          `BSIT_A_FMSK: rdata_q <= fmsk_q;
          `BSIT_A_ABASE: rdata_q <= abase_q;
          `BSIT_A_AMASK: rdata_q <= amask_q;
          `BSIT_A_STAT: rdata_q <= {24'h000000, spm_q, 2'b00, sp_q == SP_WAIT, debug_mode};
          default: rdata_q <= `BSIT_RST_WORD;
        endcase
      end
    end else begin
      rdata_q <= `BSIT_RST_WORD;
    end
  end
  assign reg_rdata = rdata_q;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_filt;
    @(posedge clk) disable iff (!reset_n)
    fctl_q[`BSIT_F_SF] & masked & hready & (htrans == HT_NSEQ) |=> !evt_nseq && !evt_read && !evt_write;
  endproperty
  a_filt: assert property (p_filt) else $error("masked transfer raised an event");

  property p_seq;
    @(posedge clk) disable iff (!reset_n)
    pass & hready & (htrans == HT_SEQ) |=> evt_seq ##1 (evt_seq == $past(pass & hready & (htrans == HT_SEQ)));
  endproperty
  a_seq: assert property (p_seq) else $error("seq event wrong");

  property p_rw;
    @(posedge clk) disable iff (!reset_n)
    evt_read |-> !evt_write && $past(hready) && !$past(hwrite) && $past(htrans[1]);
  endproperty
  a_rw: assert property (p_rw) else $error("read event without read transfer");

  property p_size;
    @(posedge clk) disable iff (!reset_n)
    pass & xfer & (hsize == 3'h2) |=> evt_hsize == 6'h04;
  endproperty
  a_size: assert property (p_size) else $error("size event wrong");

  property p_ws;
    @(posedge clk) disable iff (!reset_n)
    dp_pass_q & !hready & (hresp == HR_OKAY) |=> wait_state_event;
  endproperty
  a_ws: assert property (p_ws) else $error("wait state missed");

  property p_spl;
    @(posedge clk) disable iff (!reset_n)
    split_first & (sp_q == SP_IDLE) |=> evt_split_delay && (spm_q == $past(dp_master_q));
  endproperty
  a_spl: assert property (p_spl) else $error("split master not stored");

  property p_one;
    @(posedge clk) disable iff (!reset_n)
    (sp_q == SP_WAIT) & !regrant |=> evt_split_delay && $stable(spm_q);
  endproperty
  a_one: assert property (p_one) else $error("second split disturbed tracking");

  property p_lock;
    @(posedge clk) disable iff (!reset_n)
    pass & hmastlock [*2] |-> evt_locked [*2];
  endproperty
  a_lock: assert property (p_lock) else $error("locked event dropped");

  property p_ptr;
    @(posedge clk) disable iff (!reset_n)
    trace_go & !ctrl_wr |=> wptr_q == $past(wptr_q) + 6'h01;
  endproperty
  a_ptr: assert property (p_ptr) else $error("trace pointer not advanced");

  property p_susp;
    @(posedge clk) disable iff (!reset_n)
    debug_mode & !ctrl_wr & !tt_wr |=> $stable(wptr_q) && $stable(ttag_q);
  endproperty
  a_susp: assert property (p_susp) else $error("trace ran in debug mode");

  property p_wlock;
    @(posedge clk) disable iff (!reset_n)
    !debug_mode & reg_wr & (reg_addr == `BSIT_A_CTRL0) & !boot_q |=> $stable(filt_q) && $stable(en_q);
  endproperty
  a_wlock: assert property (p_wlock) else $error("control 0 written in normal mode");

  c_split: cover property (@(posedge clk) disable iff (!reset_n) evt_split_delay ##[1:50] !evt_split_delay);
  c_wrap: cover property (@(posedge clk) disable iff (!reset_n) trace_go & (wptr_q == 6'h3f));
  c_lock: cover property (@(posedge clk) disable iff (!reset_n) evt_locked [*3]);
  c_mask: cover property (@(posedge clk) disable iff (!reset_n) fctl_q[`BSIT_F_SF] & masked & xfer);

endmodule : bsit_top

/* File: tb/bsit_ahb_model.sv */
// traced bus partner: slave-side bus signals with two-cycle non-okay responses
`timescale 1ns/1ns
module bsit_ahb_model import bsit_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // wanted next cycle
  input wire logic [1:0] c_trans,
  input wire logic c_ready,
  input wire logic c_write,
  input wire logic [2:0] c_size,
  input wire logic [1:0] c_resp,
  input wire logic [3:0] c_master,
  input wire logic c_lock,
  input wire logic [31:0] c_addr,
  // bus toward the block
  output logic [1:0] htrans,
  output logic hready,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [1:0] hresp,
  output logic [3:0] hmaster,
  output logic hmastlock,
  output logic [31:0] haddr
);
  // ----------------------------------------
  // bus driver
  // ----------------------------------------
  logic second_q;

  // a non-okay response is ready low then high; the second cycle cancels the next transfer
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      htrans <= HT_IDLE;
      hready <= 1'h1;
      hresp <= HR_OKAY;
      hmastlock <= 1'h0;
      second_q <= 1'h0;
    end else if (second_q) begin
      htrans <= HT_IDLE;
      hready <= 1'h1;
      second_q <= 1'h0;
    end else begin
      htrans <= c_trans;
      hmastlock <= c_lock;
      hresp <= c_resp;
      hready <= (c_resp == HR_OKAY) ? c_ready : 1'h0;
      second_q <= (c_resp != HR_OKAY);
    end
  end

  // address-phase qualifiers follow the command every cycle
  always_ff @(posedge clk) begin
    hwrite <= c_write;
    hsize <= c_size;
    hmaster <= c_master;
    haddr <= c_addr;
  end
endmodule : bsit_ahb_model

/* File: tb/bsit_bench.sv */
// self-checking bench for the bus statistics and instruction trace block
`timescale 1ns/1ns
`include "bsit_defines.svh"
module bsit_bench import bsit_pkg::*;;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clk = 1'h0;
  logic reset_n = 1'h0;
  logic [15:0] reg_addr = 16'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
  logic reg_wr = 1'h0, reg_rd = 1'h0;
  logic [1:0] c_trans = 2'h0, c_resp = 2'h0, htrans, hresp;
  logic c_ready = 1'h1, c_write = 1'h0, c_lock = 1'h0, hready, hwrite, hmastlock;
  logic [2:0] c_size = 3'h0, hsize;
  logic [3:0] c_master = 4'h0, hmaster, hslave = 4'h0;
  logic [31:0] c_addr = 32'h0, haddr;
  logic evt_idle, evt_busy, evt_nseq, evt_seq, evt_read, evt_write, wait_state_event;
  logic evt_retry, evt_split, evt_split_delay, evt_locked, asi_bus_suppress;
  logic [5:0] evt_hsize;
  logic debug_mode = 1'h0, debug_enable_in = 1'h1, ext_break_in = 1'h0;
  logic instr_valid = 1'h0, instr_store = 1'h0, instr_trap = 1'h0, instr_error = 1'h0;
  logic instr_second = 1'h0, instr_target = 1'h0;
  logic [31:0] instr_opcode = 32'h0, instr_pc = 32'h0, instr_result = 32'h0, instr_store_addr = 32'h0;
  logic [31:0] seed = 32'h4623, e_pc, e_res, e_sa;
  logic [1:0] e_tr;
  logic mon_on = 1'h0, filt = 1'h0, sfilt = 1'h0;
  logic [15:0] exp_q = 16'h0;
  int n_mismatch = 0, samples_checked = 0, n;
  logic [3:0] codes [8] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'hc, 4'hd, 4'he};
  logic [31:0] ops [7] = '{32'h4000_0000, 32'h0100_0000, 32'h8000_0000, 32'hc000_0000,
    32'hc080_1000, 32'hc080_0140, 32'h1080_0000};

  always #20 clk = ~clk;

  bsit_top dut_u (.clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .htrans, .hready, .hwrite, .hsize, .hresp, .hmaster, .hmastlock, .haddr, .hslave,
    .evt_idle, .evt_busy, .evt_nseq, .evt_seq, .evt_read, .evt_write, .evt_hsize,
    .wait_state_event, .evt_retry, .evt_split, .evt_split_delay, .evt_locked,
    .debug_mode, .debug_enable_in, .ext_break_in, .instr_valid, .instr_opcode, .instr_pc,
    .instr_result, .instr_store, .instr_store_addr, .instr_trap, .instr_error,
    .instr_second, .instr_target, .asi_bus_suppress);

  bsit_ahb_model bus_u (.clk, .reset_n, .c_trans, .c_ready, .c_write, .c_size, .c_resp,
    .c_master, .c_lock, .c_addr, .htrans, .hready, .hwrite, .hsize, .hresp, .hmaster,
    .hmastlock, .haddr);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // events expected one cycle after this bus cycle; masked reads or upper slaves give none when filtering
  function logic [15:0] ev_f(input logic [1:0] t, input logic r, w, input logic [2:0] s,
      input logic [1:0] p, input logic l);
    logic q;
    q = r & t[1];
    if (q && ((filt && !w) || (sfilt && hslave[3]))) return 16'h0;
    return {r && t == 2'h0, r && t == 2'h1, r && t == 2'h2, r && t == 2'h3, q & !w, q & w,
      q ? 6'(6'h1 << s) : 6'h0, !r && p == 2'h0, 2'h0, l};
  endfunction : ev_f

  // which opcodes a trace filter code lets through
  function logic pass(input logic [3:0] c, input logic [31:0] o);
    case (c)
      4'h0: return 1'h1;
      4'h1: return o[31:30] == 2'h0;
      4'h2: return o[31:30] == 2'h1 || (o[31:30] == 2'h0 && o[24:22] == 3'h2);
      4'h4: return o[31:30] == 2'h1;
      4'h8: return o[31:30] == 2'h2;
      4'hc: return o[31:30] == 2'h3;
      4'hd: return o[31:30] == 2'h3 && o[23];
      4'he: return o[31:30] == 2'h3 && o[23] && !o[13] && o[12];
      default: return 1'h0;
    endcase
  endfunction : pass

  task conclude();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude

  task chk_w(input logic [31:0] g, e);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_w

  task wr(input logic [15:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask : wr

  task rd(input logic [15:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    @(negedge clk);
    v = reg_rdata;
  endtask : rd

  task dbg(input logic b);
    @(posedge clk);
    debug_mode <= b;
  endtask : dbg

  task instr(input logic [31:0] o, input logic s, sc);
    logic [31:0] r;
    r = rnd();
    @(posedge clk);
    instr_valid <= 1'h1;
    instr_opcode <= o;
    instr_store <= s;
    instr_second <= sc;
    instr_pc <= rnd();
    instr_result <= rnd();
    instr_store_addr <= rnd();
    instr_trap <= r[0];
    instr_error <= r[1];
    @(negedge clk);
    chk_w(asi_bus_suppress, pass(4'he, o));
    @(posedge clk);
    instr_valid <= 1'h0;
  endtask : instr

  // random bus traffic; only write/read nonsequential transfers when nseq is set
  task traffic(input int cnt, input logic nseq);
    logic [31:0] r;
    for (int i = 0; i < cnt; i++) begin
      r = rnd();
      @(posedge clk);
      c_trans <= nseq ? 2'h2 : r[1:0];
      c_ready <= nseq | r[2];
      c_write <= r[3];
      c_size <= r[6:4];
      c_lock <= !nseq & r[7];
      c_master <= r[11:8];
      c_addr <= {r[15:0], r[31:16]};
      hslave <= r[15:12];
      mon_on = (i > 1);
    end
    @(posedge clk);
    mon_on = 1'h0;
  endtask : traffic

  // one transfer by master m, then a non-okay response; bounded wait for its event
  task resp(input logic [1:0] p, input logic [3:0] m);
    int i;
    @(posedge clk);
    c_trans <= HT_NSEQ;
    c_ready <= 1'h1;
    c_master <= m;
    c_lock <= 1'h0;
    @(posedge clk);
    c_trans <= HT_IDLE;
    c_resp <= p;
    @(posedge clk);
    c_resp <= HR_OKAY;
    for (i = 0; i < 8 && !(p == HR_RETRY ? evt_retry : evt_split); i++) @(negedge clk);
    chk_w(32'(i < 8), 32'h1);
    if (i == 8) begin
      n_mismatch++;
      conclude();
    end
  endtask : resp

  // compared at the falling edge, where every flop of the last rising edge has settled
  always @(negedge clk) begin
    if (mon_on) chk_w({evt_idle, evt_busy, evt_nseq, evt_seq, evt_read, evt_write, evt_hsize,
      wait_state_event, evt_retry, evt_split, evt_locked}, exp_q);
    exp_q = ev_f(htrans, hready, hwrite, hsize, hresp, hmastlock);
  end

  initial begin
    #2000000;
    n_mismatch++;
    conclude();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1'h1;
    rd(`BSIT_A_CTRL0, d);
    chk_w(d[16], 32'h1);
    rd(`BSIT_A_FCTL, d);
    chk_w(d, 32'h0);
    rd(16'h0040, d);
    chk_w(d, 32'h0);
    $display("test reset done");
    traffic(400, 1'h0);
    wr(`BSIT_A_FCTL, 32'h3);
    filt = 1'h1;
    traffic(60, 1'h1);
    filt = 1'h0;
    // slaves 8 to 15 masked through the slave half of the mask word
    wr(`BSIT_A_FMSK, 32'hff00_0000);
    wr(`BSIT_A_FCTL, 32'h1);
    sfilt = 1'h1;
    traffic(60, 1'h1);
    sfilt = 1'h0;
    wr(`BSIT_A_FCTL, 32'h0);
    $display("test events done");
    resp(HR_SPLIT, 4'h3);
    chk_w(evt_split_delay, 32'h1);
    resp(HR_SPLIT, 4'h5);
    chk_w(evt_split_delay, 32'h1);
    rd(`BSIT_A_STAT, d);
    chk_w(d[7:4], 32'h3);
    resp(HR_RETRY, 4'h3);
    chk_w(evt_split_delay, 32'h0);
    $display("test split done");
    dbg(1'h1);
    wr(`BSIT_A_CTRL0, 32'h0001_0000);
    wr(`BSIT_A_TTAG, 32'h0000_0100);
    rd(`BSIT_A_TTAG, d);
    chk_w(d, 32'h0000_0100);
    dbg(1'h0);
    instr(32'h8000_0000, 1'h0, 1'h0);
    e_pc = instr_pc;
    e_res = instr_result;
    e_tr = {instr_trap, instr_error};
    instr(32'hc068_0000, 1'h1, 1'h1);
    e_sa = instr_store_addr;
    wr(`BSIT_A_CTRL0, 32'he000_0000);
    wr(16'h100c, 32'h0);
    dbg(1'h1);
    rd(16'h1000, d);
    chk_w(d[31:30], 32'h0);
    chk_w(d[29:0], 32'h101);
    rd(16'h1004, d);
    chk_w(d, e_res);
    rd(16'h1008, d);
    chk_w(d, {e_pc[31:2], e_tr});
    rd(16'h100c, d);
    chk_w(d, 32'h8000_0000);
    rd(16'h1010, d);
    chk_w(d[31:30], 32'h1);
    rd(16'h1014, d);
    chk_w(d, e_sa);
    instr(32'h8000_0000, 1'h0, 1'h0);
    rd(`BSIT_A_CTRL0, d);
    chk_w(d, 32'h0001_0002);
    wr(`BSIT_A_CTRL0, 32'h0001_003f);
    dbg(1'h0);
    instr(32'h8000_0000, 1'h0, 1'h0);
    dbg(1'h1);
    rd(`BSIT_A_CTRL0, d);
    chk_w(d[5:0], 32'h0);
    $display("test trace done");
    // each filter code sees every opcode class once; the pointer counts the traced ones
    for (int i = 0; i < 8; i++) begin
      n = 0;
      wr(`BSIT_A_CTRL0, {codes[i], 28'h001_0000});
      dbg(1'h0);
      for (int j = 0; j < 7; j++) begin
        instr(ops[j], 1'h0, 1'h0);
        n += pass(codes[i], ops[j]);
      end
      dbg(1'h1);
      rd(`BSIT_A_CTRL0, d);
      chk_w(d[5:0], 32'(n));
    end
    $display("test filter done");
    conclude();
  end
endmodule : bsit_bench
